// [verilog/pause_pkg.sv]
package pause_pkg;

  // ----------------------------------------------------------------
  // Class layout and field widths
  // ----------------------------------------------------------------
  localparam int NCLASS = 9;
  localparam int NPRIO  = 8;
  localparam int GBIT   = 8;
  localparam int QW     = 16;
  localparam int AW     = 48;
  localparam logic [AW-1:0] PAUSE_MCAST_ADDR = 48'h0180c2000001;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int LINE_RATE_GBPS  = 40;
  localparam int BITS_PER_QUANTA = 512;
  localparam int CLK_PERIOD_PS   = 4000;
  localparam int QUANTA_TIME_PS  = BITS_PER_QUANTA * 1000 / LINE_RATE_GBPS;
  // Whole core cycles per quanta, at least one
  localparam int QUANTA_CYCLES   = (QUANTA_TIME_PS / CLK_PERIOD_PS < 1) ?
                                   1 : QUANTA_TIME_PS / CLK_PERIOD_PS;
  localparam int QDIV_W          = 8;
  localparam int ACK_TIMEOUT_CYCLES = 32;
  localparam int ACK_CNT_W       = 6;
  localparam int MIN_HOLD_CYCLES = 16;
  localparam int HOLD_CNT_W      = 5;

  // ----------------------------------------------------------------
  // Generated frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BYTES = 60;
  localparam int TOTAL_BYTES = 64;
  localparam int IDX_W       = 6;
  localparam int FRAME_BITS  = FRAME_BYTES * 8;
  localparam int GPAD_BITS   = FRAME_BITS - 144;
  localparam int PPAD_BITS   = FRAME_BITS - 272;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [NPRIO-1:0][QW-1:0]  quanta_arr_t;
  typedef logic [NCLASS-1:0][QW-1:0] refresh_arr_t;

  typedef struct packed {
    logic [AW-1:0] tx_global_frame_dest_addr;
    logic [AW-1:0] tx_global_frame_src_addr;
    logic [QW-1:0] global_etype;
    logic [QW-1:0] global_opcode;
    logic [QW-1:0] tx_global_quanta_value;
    logic [AW-1:0] tx_priority_frame_dest_addr;
    logic [AW-1:0] tx_priority_frame_src_addr;
    logic [QW-1:0] prio_etype;
    logic [QW-1:0] prio_opcode;
    quanta_arr_t   tx_class_quanta_value_n;
  } tx_cfg_t;

  typedef struct packed {
    logic          chk_group;
    logic          chk_indiv;
    logic          chk_src;
    logic          chk_etype;
    logic          chk_opcode;
    logic          enable;
    logic [QW-1:0] etype;
    logic [QW-1:0] op_lo;
    logic [QW-1:0] op_hi;
  } match_cfg_t;

  typedef struct packed {
    logic [AW-1:0] rx_expected_indiv_dest_addr;
    logic [AW-1:0] rx_expected_group_dest_addr;
    logic [AW-1:0] rx_expected_src_addr;
    logic          forward_ctrl;
    logic          check_ack;
    match_cfg_t    gcp;
    match_cfg_t    pcp;
    match_cfg_t    gpp;
    match_cfg_t    ppp;
  } rx_cfg_t;

  typedef enum logic [3:0] {
    RX_IDLE      = 4'b0001,
    RX_WAIT_ACK  = 4'b0010,
    RX_COUNT     = 4'b0100,
    RX_WAIT_DROP = 4'b1000
  } rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } tx_state_t;

endpackage

// [verilog/pause_if.sv]
`timescale 1ns/1ps
interface pause_if;
  import pause_pkg::*;

  logic [NCLASS-1:0] tx_req;
  logic [NCLASS-1:0] tx_en;
  logic              tx_resend;
  refresh_arr_t      tx_refresh;
  tx_cfg_t           tx_cfg;
  logic [NCLASS-1:0] rx_en;
  logic [NCLASS-1:0] rx_ack;
  logic [NCLASS-1:0] rx_req;
  rx_cfg_t           rx_cfg;

  modport mac (
    input  tx_req, tx_en, tx_resend, tx_refresh, tx_cfg,
    input  rx_en, rx_ack, rx_cfg,
    output rx_req
  );

  modport user (
    output tx_req, tx_en, tx_resend, tx_refresh, tx_cfg,
    output rx_en, rx_ack, rx_cfg,
    input  rx_req
  );
endinterface

// [verilog/user_flow_ctrl.sv]
`timescale 1ns/1ps
module user_flow_ctrl (
  input  wire logic                      core_clk,
  input  wire logic                      rstn,
  pause_if.user                          lk,
  input  wire logic [pause_pkg::NCLASS-1:0] want_pause,
  input  wire logic [pause_pkg::NCLASS-1:0] want_enable,
  input  wire logic                      want_resend,
  input  wire pause_pkg::refresh_arr_t   refresh_in,
  input  wire pause_pkg::tx_cfg_t        tx_cfg_in,
  input  wire pause_pkg::rx_cfg_t        rx_cfg_in,
  input  wire logic [pause_pkg::NCLASS-1:0] rx_enable_in,
  output logic [pause_pkg::NCLASS-1:0]   pause_seen
);
  import pause_pkg::*;

  localparam int NCTL = 2 * NCLASS;

  logic [NCTL-1:0]       target;
  logic [NCTL-1:0]       ctl;
  logic                  resend_prev;
  logic                  resend_q;
  logic [NCLASS-1:0]     ack_q;
  logic [NCLASS-1:0]     rx_en_q;
  refresh_arr_t          refresh_q;
  tx_cfg_t               tx_cfg_q;
  rx_cfg_t               rx_cfg_q;

  // ----------------------------------------------------------------
  // Request shaping
  // ----------------------------------------------------------------
  always_comb
  begin
    target = {want_enable, want_pause};
    if (want_pause[GBIT])
      target[NPRIO-1:0] = '0;
  end

  // Each control bit only moves after a minimum dwell
  for (genvar b = 0; b < NCTL; b++)
  begin : g_hold
    logic [HOLD_CNT_W-1:0] dwell;
    always_ff @(posedge core_clk)
    begin
      if (!rstn)
      begin
        ctl[b] <= 1'b0;
        dwell  <= '0;
      end
      else if (target[b] != ctl[b] &&
               dwell >= HOLD_CNT_W'(MIN_HOLD_CYCLES - 1))
      begin
        ctl[b] <= target[b];
        dwell  <= '0;
      end
      else if (dwell < HOLD_CNT_W'(MIN_HOLD_CYCLES - 1))
        dwell <= dwell + 1'b1;
    end
  end

  assign lk.tx_req = ctl[NCLASS-1:0];
  assign lk.tx_en  = ctl[NCTL-1:NCLASS];

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      resend_prev <= 1'b0;
      resend_q    <= 1'b0;
    end
    else
    begin
      resend_prev <= want_resend;
      resend_q    <= want_resend & ~resend_prev;
    end
  end
  assign lk.tx_resend = resend_q;

  // ----------------------------------------------------------------
  // Receive handshake: ack follows the request one cycle later
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      ack_q      <= '0;
      pause_seen <= '0;
    end
    else
    begin
      ack_q      <= lk.rx_req;
      pause_seen <= lk.rx_req;
    end
  end
  assign lk.rx_ack = ack_q;

  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      refresh_q <= '0;
      tx_cfg_q  <= '0;
      rx_cfg_q  <= '0;
      rx_en_q   <= '0;
    end
    else
    begin
      refresh_q <= refresh_in;
      tx_cfg_q  <= tx_cfg_in;
      rx_cfg_q  <= rx_cfg_in;
      rx_en_q   <= rx_enable_in;
    end
  end
  assign lk.tx_refresh = refresh_q;
  assign lk.tx_cfg     = tx_cfg_q;
  assign lk.rx_cfg     = rx_cfg_q;
  assign lk.rx_en      = rx_en_q;

endmodule

// [verilog/mac_pause_ctrl.sv]
`timescale 1ns/1ps
module mac_pause_ctrl (
  input  wire logic                   core_clk,
  input  wire logic                   rstn,
  pause_if.mac                        lk,
  input  wire logic                   tx_in_flight,
  output logic [7:0]                  tx_byte,
  output logic                        tx_byte_valid,
  output logic                        tx_byte_last,
  input  wire logic                   rx_frame_valid,
  input  wire logic [pause_pkg::AW-1:0] rx_da,
  input  wire logic [pause_pkg::AW-1:0] rx_sa,
  input  wire logic [pause_pkg::QW-1:0] rx_etype,
  input  wire logic [pause_pkg::QW-1:0] rx_opcode,
  input  wire logic [pause_pkg::NPRIO-1:0] rx_class_vec,
  input  wire pause_pkg::quanta_arr_t rx_quanta,
  output logic                        rx_ctrl_forward,
  output logic                        rx_ctrl_drop
);
  import pause_pkg::*;

  // ----------------------------------------------------------------
  // Quanta tick
  // ----------------------------------------------------------------
  logic [QDIV_W-1:0] div_cnt;
  logic              tick;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      div_cnt <= '0;
      tick    <= 1'b0;
    end
    else if (div_cnt == QDIV_W'(QUANTA_CYCLES - 1))
    begin
      div_cnt <= '0;
      tick    <= 1'b1;
    end
    else
    begin
      div_cnt <= div_cnt + 1'b1;
      tick    <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transmit scheduling
  // ----------------------------------------------------------------
  logic [NCLASS-1:0]     active;
  logic [NCLASS-1:0]     prev_active;
  logic [NCLASS-1:0]     trigger;
  logic [NCLASS-1:0]     pend;
  logic [NCLASS-1:0]     next_pend;
  logic [NCLASS-1:0]     sent;
  logic [NCLASS-1:0][QW-1:0] tx_timer;
  logic                  start;
  tx_state_t             tx_state;
  logic [FRAME_BITS-1:0] frame_sh;
  logic [IDX_W-1:0]      idx;
  logic [31:0]           crc;

  assign active = lk.tx_req & lk.tx_en;

  always_comb
  begin
    for (int i = 0; i < NCLASS; i++)
      trigger[i] = active[i] &
                   ((tx_timer[i] == '0) | ~prev_active[i]);
  end

  assign start = (tx_state == TX_IDLE) && (|pend) && !tx_in_flight;

  always_comb
  begin
    sent = pend[GBIT] ? NCLASS'(1 << GBIT) : {1'b0, active[NPRIO-1:0]};
    next_pend = (pend | trigger) & active;
    if (|next_pend[NPRIO-1:0])
      next_pend[NPRIO-1:0] = active[NPRIO-1:0];
    if (start)
      next_pend = '0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      pend        <= '0;
      prev_active <= '0;
    end
    else
    begin
      pend        <= next_pend;
      prev_active <= active;
    end
  end

  for (genvar i = 0; i < NCLASS; i++)
  begin : g_tx_timer
    always_ff @(posedge core_clk)
    begin
      if (!rstn)
        tx_timer[i] <= '0;
      else if (lk.tx_resend)
        tx_timer[i] <= '0;
      else if (start && sent[i])
        tx_timer[i] <= lk.tx_refresh[i];
      else if (tick && tx_timer[i] != '0)
        tx_timer[i] <= tx_timer[i] - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Frame serialiser
  // ----------------------------------------------------------------
  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0]  d);
    logic [31:0] r;
    logic        fb;
    r = c;
    for (int b = 0; b < 8; b++)
    begin
      fb = r[0] ^ d[b];
      r  = r >> 1;
      if (fb)
        r = r ^ CRC_POLY;
    end
    return r;
  endfunction

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      tx_state      <= TX_IDLE;
      frame_sh      <= '0;
      idx           <= '0;
      crc           <= CRC_INIT;
      tx_byte       <= '0;
      tx_byte_valid <= 1'b0;
      tx_byte_last  <= 1'b0;
    end
    else
    begin
      tx_byte_valid <= 1'b0;
      tx_byte_last  <= 1'b0;
      case (tx_state)
        TX_IDLE:
          if (start)
          begin
            tx_state <= TX_SEND;
            idx      <= '0;
            crc      <= CRC_INIT;
            if (pend[GBIT])
              frame_sh <= {lk.tx_cfg.tx_global_frame_dest_addr,
                           lk.tx_cfg.tx_global_frame_src_addr,
                           lk.tx_cfg.global_etype,
                           lk.tx_cfg.global_opcode,
                           lk.tx_cfg.tx_global_quanta_value,
                           {GPAD_BITS{1'b0}}};
            else
              frame_sh <= {lk.tx_cfg.tx_priority_frame_dest_addr,
                           lk.tx_cfg.tx_priority_frame_src_addr,
                           lk.tx_cfg.prio_etype,
                           lk.tx_cfg.prio_opcode,
                           8'h00, active[NPRIO-1:0],
                           lk.tx_cfg.tx_class_quanta_value_n,
                           {PPAD_BITS{1'b0}}};
          end
        TX_SEND:
        begin
          tx_byte_valid <= 1'b1;
          idx           <= idx + 1'b1;
          if (idx < IDX_W'(FRAME_BYTES))
          begin
            tx_byte  <= frame_sh[FRAME_BITS-1 -: 8];
            crc      <= crc_byte(crc, frame_sh[FRAME_BITS-1 -: 8]);
            frame_sh <= frame_sh << 8;
          end
          else
          begin
            tx_byte <= ~crc[7:0];
            crc     <= crc >> 8;
          end
          if (idx == IDX_W'(TOTAL_BYTES - 1))
          begin
            tx_byte_last <= 1'b1;
            tx_state     <= TX_IDLE;
          end
        end
        default:
          tx_state <= TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive classification
  // ----------------------------------------------------------------
  function automatic logic frame_ok(input match_cfg_t      m,
                                    input logic [AW-1:0]  group,
                                    input logic           exact);
    logic da_ok;
    logic op_ok;
    da_ok = (!m.chk_group && !m.chk_indiv) ||
            (m.chk_indiv &&
             rx_da == lk.rx_cfg.rx_expected_indiv_dest_addr) ||
            (m.chk_group && rx_da == group);
    op_ok = exact ? (rx_opcode == m.op_lo) :
                    (rx_opcode >= m.op_lo && rx_opcode <= m.op_hi);
    return da_ok && m.enable && (!m.chk_opcode || op_ok) &&
           (!m.chk_src || rx_sa == lk.rx_cfg.rx_expected_src_addr) &&
           (!m.chk_etype || rx_etype == m.etype);
  endfunction

  logic              is_ctrl;
  logic              is_gpp;
  logic              is_ppp;
  logic [NCLASS-1:0] hit;

  always_comb
  begin
    is_ctrl = frame_ok(lk.rx_cfg.gcp, PAUSE_MCAST_ADDR, 1'b0) ||
              frame_ok(lk.rx_cfg.pcp,
                       lk.rx_cfg.rx_expected_group_dest_addr,
                       1'b0);
    is_gpp  = is_ctrl && frame_ok(lk.rx_cfg.gpp, PAUSE_MCAST_ADDR, 1'b1);
    is_ppp  = is_ctrl && !is_gpp &&
              frame_ok(lk.rx_cfg.ppp,
                       lk.rx_cfg.rx_expected_group_dest_addr,
                       1'b1);
    hit     = {rx_frame_valid & is_gpp,
               {NPRIO{rx_frame_valid & is_ppp}} & rx_class_vec};
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      rx_ctrl_forward <= 1'b0;
      rx_ctrl_drop    <= 1'b0;
    end
    else
    begin
      rx_ctrl_forward <= rx_frame_valid & is_ctrl &
                         lk.rx_cfg.forward_ctrl;
      rx_ctrl_drop    <= rx_frame_valid & is_ctrl &
                         ~lk.rx_cfg.forward_ctrl;
    end
  end

  // ----------------------------------------------------------------
  // Receive handshake, one machine per class
  // ----------------------------------------------------------------
  rx_state_t            rx_state [NCLASS];
  logic [QW-1:0]        rx_timer [NCLASS];
  logic [ACK_CNT_W-1:0] drop_cnt [NCLASS];
  logic [NCLASS-1:0]    rx_req_q;
  logic [NCLASS-1:0][QW-1:0] q_in;

  assign lk.rx_req = rx_req_q;
  assign q_in      = {rx_quanta[0], rx_quanta};

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      rx_req_q <= '0;
      for (int i = 0; i < NCLASS; i++)
      begin
        rx_state[i] <= RX_IDLE;
        rx_timer[i] <= '0;
        drop_cnt[i] <= '0;
      end
    end
    else
    begin
      for (int i = 0; i < NCLASS; i++)
      begin
        case (rx_state[i])
          RX_IDLE:
            if (hit[i] && lk.rx_en[i])
            begin
              rx_req_q[i] <= 1'b1;
              rx_timer[i] <= q_in[i];
              rx_state[i] <= lk.rx_cfg.check_ack ? RX_WAIT_ACK
                                                 : RX_COUNT;
            end
          RX_WAIT_ACK:
            // Enable is not looked at past idle
            if (hit[i])
              rx_timer[i] <= q_in[i];
            else if (lk.rx_ack[i])
              rx_state[i] <= RX_COUNT;
          RX_COUNT:
            if (hit[i])
              rx_timer[i] <= q_in[i];
            else if (rx_timer[i] == '0)
            begin
              rx_req_q[i] <= 1'b0;
              drop_cnt[i] <= '0;
              rx_state[i] <= lk.rx_cfg.check_ack ? RX_WAIT_DROP
                                                 : RX_IDLE;
            end
            else if (tick)
              rx_timer[i] <= rx_timer[i] - 1'b1;
          RX_WAIT_DROP:
            if (hit[i])
            begin
              rx_req_q[i] <= 1'b1;
              rx_timer[i] <= q_in[i];
              rx_state[i] <= RX_WAIT_ACK;
            end
            else if (!lk.rx_ack[i] ||
                     drop_cnt[i] == ACK_CNT_W'(ACK_TIMEOUT_CYCLES - 1))
              rx_state[i] <= RX_IDLE;
            else
              drop_cnt[i] <= drop_cnt[i] + 1'b1;
          default:
            rx_state[i] <= RX_IDLE;
        endcase
      end
    end
  end

endmodule

// [verification/pause_props.sv]
`timescale 1ns/1ps
module pause_props (
  input wire logic                         core_clk,
  input wire logic                         rstn,
  input wire logic [pause_pkg::NCLASS-1:0] tx_req,
  input wire logic [pause_pkg::NCLASS-1:0] tx_en,
  input wire logic                         tx_resend,
  input wire logic [pause_pkg::NCLASS-1:0] rx_en,
  input wire logic [pause_pkg::NCLASS-1:0] rx_ack,
  input wire logic [pause_pkg::NCLASS-1:0] rx_req,
  input wire pause_pkg::rx_cfg_t           rx_cfg
);
  import pause_pkg::*;

  // ------------------------------
  // Age of each control bit
  // ------------------------------
  wire logic [2*NCLASS-1:0] ctl_now = {tx_en, tx_req};
  logic      [2*NCLASS-1:0] ctl_prev;
  logic      [2*NCLASS-1:0] held;
  logic      [3:0]          age [2*NCLASS];

  // Reset is no transition
  always_ff @(posedge core_clk)
  begin
    ctl_prev <= ctl_now;
    for (int i = 0; i < 2*NCLASS; i++)
      if (!rstn)
        age[i] <= 4'hf;
      else if (ctl_now[i] != ctl_prev[i])
        age[i] <= 4'h0;
      else if (age[i] != 4'hf)
        age[i] <= age[i] + 4'h1;
  end

  always_comb
    for (int i = 0; i < 2*NCLASS; i++)
      held[i] = (age[i] == 4'hf);

  // ------------------------------
  // Properties
  // ------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_req_up;
    rx_cfg.check_ack && $rose(rx_req[GBIT]);
  endsequence
  sequence s_acked;
    rx_ack[GBIT] && rx_req[GBIT] ##1 rx_req[GBIT];
  endsequence

  property p_resend_pulse;
    tx_resend |=> !tx_resend;
  endproperty
  property p_no_mix;
    tx_req[GBIT] && tx_en[GBIT] |-> (tx_req[7:0] & tx_en[7:0]) == '0;
  endproperty
  property p_hold;
    ((ctl_now ^ ctl_prev) & ~held) == '0;
  endproperty
  property p_rise_needs_en;
    (rx_req & ~$past(rx_req) & ~$past(rx_en)) == '0;
  endproperty
  property p_fall_needs_ack;
    rx_cfg.check_ack |-> (~rx_req & $past(rx_req) & ~$past(rx_ack)) == '0;
  endproperty
  property p_ack_steps;
    s_req_up |=> s_acked;
  endproperty
  property p_ack_drop;
    $fell(rx_req[GBIT]) |=> !rx_ack[GBIT];
  endproperty
  property p_pri_ack;
    $rose(rx_req[1]) |=> rx_ack[1] ##1 rx_ack[1];
  endproperty

  a_resend_pulse: assert property (p_resend_pulse)
    else $error("resend too long");
  a_no_mix: assert property (p_no_mix)
    else $error("global mixed with priority");
  a_hold: assert property (p_hold)
    else $error("control bit changed too soon");
  a_rise_needs_en: assert property (p_rise_needs_en)
    else $error("request on disabled class");
  a_fall_needs_ack: assert property (p_fall_needs_ack)
    else $error("request dropped before ack");
  a_ack_steps: assert property (p_ack_steps)
    else $error("handshake steps out of order");
  a_ack_drop: assert property (p_ack_drop)
    else $error("ack kept after request fell");
  a_pri_ack: assert property (p_pri_ack)
    else $error("priority request not acked");
endmodule

// [verification/ethernet_pause_gen_term_tb_top.sv]
`timescale 1ns/1ps
module ethernet_pause_gen_term_tb_top;
  import pause_pkg::*;

  // ------------------------------
  // Signals and instances
  // ------------------------------
  localparam logic [AW-1:0] SRC_OK = 48'h02000000000b;
  logic              core_clk = 1'b0;
  logic              rstn;
  logic [NCLASS-1:0] want_pause;
  logic [NCLASS-1:0] want_enable;
  logic              want_resend;
  refresh_arr_t      refresh_in;
  tx_cfg_t           tx_cfg_in;
  rx_cfg_t           rx_cfg_in;
  logic [NCLASS-1:0] rx_enable_in;
  logic [NCLASS-1:0] pause_seen;
  logic              tx_in_flight;
  logic [7:0]        tx_byte;
  logic              tx_byte_valid;
  logic              tx_byte_last;
  logic              rx_frame_valid;
  logic [AW-1:0]     rx_da;
  logic [AW-1:0]     rx_sa;
  logic [QW-1:0]     rx_etype;
  logic [QW-1:0]     rx_opcode;
  logic [NPRIO-1:0]  rx_class_vec;
  quanta_arr_t       rx_quanta;
  logic              rx_ctrl_forward;
  logic              rx_ctrl_drop;
  logic [7:0]        fb [TOTAL_BYTES];
  int                mismatches = 0;
  int                checked = 0;
  int                cycles = 0;

  pause_if lk ();
  user_flow_ctrl u_user_flow_ctrl (.core_clk, .rstn, .lk, .want_pause,
    .want_enable, .want_resend, .refresh_in, .tx_cfg_in, .rx_cfg_in,
    .rx_enable_in, .pause_seen);
  mac_pause_ctrl u_mac_pause_ctrl (.core_clk, .rstn, .lk, .tx_in_flight,
    .tx_byte, .tx_byte_valid, .tx_byte_last, .rx_frame_valid, .rx_da,
    .rx_sa, .rx_etype, .rx_opcode, .rx_class_vec, .rx_quanta,
    .rx_ctrl_forward, .rx_ctrl_drop);
  pause_props u_pause_props (.core_clk, .rstn, .tx_req(lk.tx_req),
    .tx_en(lk.tx_en), .tx_resend(lk.tx_resend), .rx_en(lk.rx_en),
    .rx_ack(lk.rx_ack), .rx_req(lk.rx_req), .rx_cfg(lk.rx_cfg));

  always #2 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  // ------------------------------
  // Shared tasks
  // ------------------------------
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] seen,
                     input logic [63:0] expv);
    checked++;
    if (seen !== expv)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, expv, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  function automatic match_cfg_t mc(input logic [QW-1:0] lo, hi);
    return '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 16'h8808, lo, hi};
  endfunction

  function automatic logic [63:0] fld(input int off, input int len);
    logic [63:0] v;
    v = '0;
    for (int i = 0; i < len; i++)
      v = {v[55:0], fb[off+i]};
    return v;
  endfunction

  function automatic logic [31:0] fcs();
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 0; i < FRAME_BYTES; i++)
    begin
      c = c ^ {24'h000000, fb[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction

  // Falling edge in and out
  task automatic grab(output int n);
    n = 0;
    while (tx_byte_valid !== 1'b1 && n < 300)
    begin
      @(negedge core_clk);
      n++;
    end
    for (int i = 0; i < TOTAL_BYTES; i++)
    begin
      fb[i] = tx_byte;
      chk("strobe", {tx_byte_valid, tx_byte_last}, {1'b1, i == 63});
      @(negedge core_clk);
    end
    chk("fcs", {fb[63], fb[62], fb[61], fb[60]}, fcs());
  endtask

  task automatic rx_send(input logic [QW-1:0] op, input logic [7:0] cv,
                         input logic [AW-1:0] sa, input logic [1:0] ctl,
                         input logic [NCLASS-1:0] req, input logic [QW-1:0] q);
    @(posedge core_clk);
    rx_frame_valid <= 1'b1;
    rx_quanta <= {NPRIO{q}};
    rx_sa <= sa;
    rx_opcode <= op;
    rx_class_vec <= cv;
    @(posedge core_clk);
    rx_frame_valid <= 1'b0;
    @(negedge core_clk);
    chk("ctl", {rx_ctrl_forward, rx_ctrl_drop}, ctl);
    chk("rx_req", lk.rx_req, req);
    @(negedge core_clk);
    chk("seen", pause_seen, req);
  endtask

  task automatic hold(input int b, output int n);
    n = 0;
    while (lk.rx_req[b] === 1'b1 && n < 400)
    begin
      @(negedge core_clk);
      n++;
    end
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_global();
    int n;
    int busy;
    busy = 0;
    tx_in_flight <= 1'b1;
    want_pause[GBIT] <= 1'b1;
    repeat (40)
    begin
      @(negedge core_clk);
      busy += tx_byte_valid;
    end
    chk("held", busy, 0);
    @(posedge core_clk);
    tx_in_flight <= 1'b0;
    @(negedge core_clk);
    grab(n);
    chk("start", n, 2);
    chk("da", fld(0, 6), tx_cfg_in.tx_global_frame_dest_addr);
    chk("sa", fld(6, 6), tx_cfg_in.tx_global_frame_src_addr);
    chk("op", fld(12, 4), 32'h88080001);
    chk("q", fld(16, 2), tx_cfg_in.tx_global_quanta_value);
    chk("pad", fld(18, 8), 0);
    @(posedge core_clk);
    want_pause[GBIT] <= 1'b0;
  endtask

  task automatic t_merge();
    int n;
    tick(20);
    tx_in_flight <= 1'b1;
    want_pause[3] <= 1'b1;
    tick(20);
    want_pause[5] <= 1'b1;
    tick(40);
    tx_in_flight <= 1'b0;
    @(negedge core_clk);
    grab(n);
    chk("one", tx_byte_valid, 0);
    chk("da", fld(0, 6), tx_cfg_in.tx_priority_frame_dest_addr);
    chk("sa", fld(6, 6), tx_cfg_in.tx_priority_frame_src_addr);
    chk("op", fld(12, 4), 32'h88080101);
    chk("vec", fld(16, 2), 16'h0028);
    chk("q5", fld(22, 2), 16'h0a05);
    chk("q3", fld(26, 2), 16'h0a03);
  endtask

  task automatic t_refresh();
    int n;
    int busy;
    @(posedge core_clk);
    want_resend <= 1'b1;
    @(negedge core_clk);
    grab(n);
    chk("resend", n < 8, 1);
    chk("vec", fld(16, 2), 16'h0028);
    @(posedge core_clk);
    want_resend <= 1'b0;
    refresh_in[3] <= 16'h0002;
    tick(4);
    want_resend <= 1'b1;
    @(negedge core_clk);
    grab(n);
    grab(n);
    chk("refresh", n, 1);
    chk("vec", fld(16, 2), 16'h0028);
    @(posedge core_clk);
    want_resend <= 1'b0;
    want_pause[5:3] <= 3'b000;
    tick(150);
    busy = 0;
    repeat (100)
    begin
      @(negedge core_clk);
      busy += tx_byte_valid;
    end
    chk("cancel", busy, 0);
  endtask

  task automatic t_rx();
    int n;
    rx_send(16'h0001, 8'h00, SRC_OK, 2'b10, 9'h100, 16'h4);
    hold(GBIT, n);
    chk("len", n >= 12 && n <= 18, 1);
    rx_send(16'h0001, 8'h00, 48'h02000000000c, 2'b00, 9'h000, 16'h4);
    rx_send(16'h0200, 8'h00, SRC_OK, 2'b00, 9'h000, 16'h4);
    rx_send(16'h0101, 8'h42, SRC_OK, 2'b10, 9'h042, 16'h2);
    tick(40);
    rx_cfg_in.forward_ctrl <= 1'b0;
    rx_enable_in[GBIT] <= 1'b0;
    tick(3);
    rx_send(16'h0001, 8'h00, SRC_OK, 2'b01, 9'h000, 16'h2);
    @(posedge core_clk);
    rx_cfg_in.forward_ctrl <= 1'b1;
    rx_cfg_in.check_ack <= 1'b0;
    rx_enable_in[GBIT] <= 1'b1;
    tick(3);
    rx_send(16'h0001, 8'h00, SRC_OK, 2'b10, 9'h100, 16'h6);
    hold(GBIT, n);
    chk("noack", n >= 15 && n <= 20, 1);
    tick(4);
    rx_cfg_in.check_ack <= 1'b1;
    tick(4);
    rx_send(16'h0001, 8'h00, SRC_OK, 2'b10, 9'h100, 16'h6);
    tick(3);
    rx_send(16'h0001, 8'h00, SRC_OK, 2'b10, 9'h100, 16'h10);
    hold(GBIT, n);
    chk("reload", n >= 45 && n <= 60, 1);
  endtask

  initial
  begin
    rstn = 1'b0;
    want_pause = '0;
    want_enable = '1;
    want_resend = 1'b0;
    refresh_in = {NCLASS{16'h0400}};
    tx_cfg_in = '{PAUSE_MCAST_ADDR, 48'h020000000011, 16'h8808, 16'h0001,
                  16'h1234, PAUSE_MCAST_ADDR, 48'h020000000022, 16'h8808,
                  16'h0101, '0};
    for (int i = 0; i < NPRIO; i++)
      tx_cfg_in.tx_class_quanta_value_n[i] = 16'h0a00 + 16'(i);
    rx_cfg_in = '{48'h02000000000a, PAUSE_MCAST_ADDR, SRC_OK, 1'b1, 1'b1,
                  mc(16'h0001, 16'h0101), mc(16'h0001, 16'h0101),
                  mc(16'h0001, 16'h0000), mc(16'h0101, 16'h0000)};
    rx_enable_in = '1;
    tx_in_flight = 1'b0;
    rx_frame_valid = 1'b0;
    rx_da = PAUSE_MCAST_ADDR;
    rx_sa = '0;
    rx_etype = 16'h8808;
    rx_opcode = '0;
    rx_class_vec = '0;
    rx_quanta = '0;
    tick(20);
    rstn <= 1'b1;
    tick(20);
    t_global();
    t_merge();
    t_refresh();
    t_rx();
    give_verdict();
  end
endmodule
